// file: inc/iepb_pkg.sv
// Purpose: constants for the interrupt enable and priority bank
// Assumes: 8-bit special-function register space, 22 sources
// Notes: source index equals fixed arbitration order
package iepb_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IEPB_ADDR_MASK_MAIN = 8'hA8;
  localparam logic [7:0] IEPB_ADDR_LEVEL_MAIN = 8'hB8;
  localparam logic [7:0] IEPB_ADDR_MASK_EXT_A = 8'hE6;
  localparam logic [7:0] IEPB_ADDR_MASK_EXT_B = 8'hE7;
  localparam logic [7:0] IEPB_ADDR_LEVEL_EXT_A = 8'hF6;
  localparam logic [7:0] IEPB_ADDR_LEVEL_EXT_B = 8'hF7;

  // ----------------------------------------------------------------
  // Reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] IEPB_RST_MASK = 8'h00;
  localparam logic [7:0] IEPB_RST_LEVEL_MAIN = 8'hC0;
  localparam logic [7:0] IEPB_RST_LEVEL_EXT = 8'h00;
  localparam logic [7:0] IEPB_LEVEL_MAIN_FIXED = 8'hC0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IEPB_BIT_GLOBAL_GATE = 7;
  localparam int IEPB_BIT_SCRATCH = 6;
  localparam int IEPB_MAIN_SRC_BITS = 6;
  localparam int IEPB_NUM_SRC = 22;
  localparam int IEPB_IDX_W = 5;

  // ----------------------------------------------------------------
  // Service state of the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IEPB_SVC_IDLE = 3'b001,
    IEPB_SVC_LOW = 3'b010,
    IEPB_SVC_HIGH = 3'b100
  } iepb_svc_type;

endpackage

// file: hw/iepb_sfr_reg.sv
// Purpose: one 8-bit special-function register with bit access
// Assumes: byte and single-bit writes never occur in one cycle
// Notes: fixed bits always read as their fixed value
`timescale 1ns/100ps
module iepb_sfr_reg #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] FIXED_MASK = 8'h00,
  parameter logic [7:0] FIXED_VAL = 8'h00
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic wr_en, // Byte write strobe
  input wire logic [7:0] wr_addr, // Byte write address
  input wire logic [7:0] wr_data, // Byte write data
  input wire logic bit_wr_en, // Single-bit write strobe
  input wire logic [7:0] bit_addr, // Register address of bit write
  input wire logic [2:0] bit_sel, // Bit position of bit write
  input wire logic bit_val, // Bit value to write
  output logic [7:0] value // Current contents
);
  logic [7:0] val_q;
  logic [7:0] val_d;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  // Byte write or single-bit read-modify-write
  always_comb begin
    val_d = val_q;
    if (wr_en && wr_addr == ADDR) begin
      val_d = wr_data;
    end else if (bit_wr_en && bit_addr == ADDR) begin
      val_d[bit_sel] = bit_val;
    end
    val_d = (val_d & ~FIXED_MASK) | (FIXED_VAL & FIXED_MASK);
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  assign value = val_q;
endmodule

// file: hw/iepb_arbiter.sv
// Purpose: fixed-order pick of the lowest set request
// Assumes: request vector is already masked
// Notes: purely combinational
`timescale 1ns/100ps
module iepb_arbiter #(
  parameter int N = 22,
  parameter int IW = 5
) (
  input wire logic [N-1:0] req, // Candidate requests
  output logic any, // Some request present
  output logic [IW-1:0] idx // Lowest set index
);
  // ----------------------------------------------------------------
  // Priority search
  // ----------------------------------------------------------------
  // Scan downward so the lowest index wins
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = IW'(i);
      end
    end
  end
endmodule

// file: hw/iepb_bank.sv
// Purpose: interrupt enable and priority register bank with decode
// Assumes: core supplies byte and bit accesses plus entry/return pulses
// Notes: source order 0..21 equals vector order, lowest first
//
// Function
// - Global gate at bit 7 low blocks every source.
// - Global gate high forwards a source only when its enable is set.
// - Bit 6 of main enable is a plain software scratch flag.
// - Disabled source never requests; enabled source's pending flag may request.
// - Main enable bits 0-5: ext0, timer0, ext1, timer1, uart0, timer2.
// - Main priority bits 0-5 follow that order; 1 means high level.
// - Main priority bits 7 and 6 read as one and ignore writes.
// - Extended enable A bits: spi, mgmt bus, adc-a window ... adc-a done.
// - Extended enable B bits: timer3, adc-b done ... uart1, dma.
// - Extended priority A uses extended enable A layout; 1 is high.
// - Extended priority B uses extended enable B layout; 1 is high.
// - All six registers decode at fixed addresses regardless of page.
// - Reset clears enables and priorities: all disabled, low level.
// - High request preempts low routine; high routine is never preempted.
// - Higher level wins; within a level lowest vector wins.
// - Pending requests are sampled and decoded every clock cycle.
// - Equal-or-higher service blocks new request until return plus one instruction.
`timescale 1ns/100ps
module iepb_bank (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic sfr_wr, // Byte write strobe
  input wire logic [7:0] sfr_wr_addr, // Byte write address
  input wire logic [7:0] sfr_wr_data, // Byte write data
  input wire logic sfr_bit_wr, // Single-bit write strobe
  input wire logic [7:0] sfr_bit_addr, // Bit write register address
  input wire logic [2:0] sfr_bit_sel, // Bit write position
  input wire logic sfr_bit_val, // Bit write value
  input wire logic [7:0] sfr_page, // Current page, ignored here
  input wire logic [7:0] sfr_rd_addr, // Read address
  output logic [7:0] sfr_rd_data, // Registered read data
  output logic sfr_rd_hit, // Registered read address hit
  input wire logic [iepb_pkg::IEPB_NUM_SRC-1:0] pend, // Pending flags, core domain
  input wire logic isr_enter, // Core takes the granted request
  input wire logic isr_return, // Core executes return
  input wire logic insn_done, // Core completes an instruction
  output logic irq_req, // Request valid toward core
  output logic [iepb_pkg::IEPB_IDX_W-1:0] irq_idx, // Winning source index
  output logic irq_hi, // Winning level, 1 is high
  output logic global_irq_gate, // Global gate bit
  output logic soft_scratch_flag // Software flag bit
);
  import iepb_pkg::*;

  logic [7:0] mask_main;
  logic [7:0] level_main;
  logic [7:0] mask_ext_a;
  logic [7:0] mask_ext_b;
  logic [7:0] level_ext_a;
  logic [7:0] level_ext_b;
  logic [IEPB_NUM_SRC-1:0] en_vec;
  logic [IEPB_NUM_SRC-1:0] hi_vec;
  logic [IEPB_NUM_SRC-1:0] live;
  logic [IEPB_NUM_SRC-1:0] live_hi;
  logic [IEPB_NUM_SRC-1:0] live_lo;
  logic any_hi;
  logic any_lo;
  logic [IEPB_IDX_W-1:0] idx_hi;
  logic [IEPB_IDX_W-1:0] idx_lo;
  logic [IEPB_NUM_SRC-1:0] pend_q;
  iepb_svc_type svc_q;
  iepb_svc_type svc_d;
  logic hi_nest_q;
  logic hi_nest_d;
  logic hold_q;
  logic hold_d;
  logic req_q;
  logic req_d;
  logic [IEPB_IDX_W-1:0] idx_q;
  logic [IEPB_IDX_W-1:0] idx_d;
  logic lvl_q;
  logic lvl_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic rd_hit_q;
  logic rd_hit_d;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Main enable: gate, scratch, six classic sources
  iepb_sfr_reg #(
    .ADDR(IEPB_ADDR_MASK_MAIN),
    .RST_VAL(IEPB_RST_MASK),
    .FIXED_MASK(8'h00),
    .FIXED_VAL(8'h00)
  ) u_mask_main (
    .clk(clk),
    .rst(rst),
    .wr_en(sfr_wr),
    .wr_addr(sfr_wr_addr),
    .wr_data(sfr_wr_data),
    .bit_wr_en(sfr_bit_wr),
    .bit_addr(sfr_bit_addr),
    .bit_sel(sfr_bit_sel),
    .bit_val(sfr_bit_val),
    .value(mask_main)
  );

  // Main priority: upper two bits pinned high
  iepb_sfr_reg #(
    .ADDR(IEPB_ADDR_LEVEL_MAIN),
    .RST_VAL(IEPB_RST_LEVEL_MAIN),
    .FIXED_MASK(IEPB_LEVEL_MAIN_FIXED),
    .FIXED_VAL(IEPB_LEVEL_MAIN_FIXED)
  ) u_level_main (
    .clk(clk),
    .rst(rst),
    .wr_en(sfr_wr),
    .wr_addr(sfr_wr_addr),
    .wr_data(sfr_wr_data),
    .bit_wr_en(sfr_bit_wr),
    .bit_addr(sfr_bit_addr),
    .bit_sel(sfr_bit_sel),
    .bit_val(sfr_bit_val),
    .value(level_main)
  );

  // Extended enable A
  iepb_sfr_reg #(
    .ADDR(IEPB_ADDR_MASK_EXT_A),
    .RST_VAL(IEPB_RST_MASK),
    .FIXED_MASK(8'h00),
    .FIXED_VAL(8'h00)
  ) u_mask_ext_a (
    .clk(clk),
    .rst(rst),
    .wr_en(sfr_wr),
    .wr_addr(sfr_wr_addr),
    .wr_data(sfr_wr_data),
    .bit_wr_en(1'b0),
    .bit_addr(sfr_bit_addr),
    .bit_sel(sfr_bit_sel),
    .bit_val(sfr_bit_val),
    .value(mask_ext_a)
  );

  // Extended enable B
  iepb_sfr_reg #(
    .ADDR(IEPB_ADDR_MASK_EXT_B),
    .RST_VAL(IEPB_RST_MASK),
    .FIXED_MASK(8'h00),
    .FIXED_VAL(8'h00)
  ) u_mask_ext_b (
    .clk(clk),
    .rst(rst),
    .wr_en(sfr_wr),
    .wr_addr(sfr_wr_addr),
    .wr_data(sfr_wr_data),
    .bit_wr_en(1'b0),
    .bit_addr(sfr_bit_addr),
    .bit_sel(sfr_bit_sel),
    .bit_val(sfr_bit_val),
    .value(mask_ext_b)
  );

  // Extended priority A
  iepb_sfr_reg #(
    .ADDR(IEPB_ADDR_LEVEL_EXT_A),
    .RST_VAL(IEPB_RST_LEVEL_EXT),
    .FIXED_MASK(8'h00),
    .FIXED_VAL(8'h00)
  ) u_level_ext_a (
    .clk(clk),
    .rst(rst),
    .wr_en(sfr_wr),
    .wr_addr(sfr_wr_addr),
    .wr_data(sfr_wr_data),
    .bit_wr_en(1'b0),
    .bit_addr(sfr_bit_addr),
    .bit_sel(sfr_bit_sel),
    .bit_val(sfr_bit_val),
    .value(level_ext_a)
  );

  // Extended priority B
  iepb_sfr_reg #(
    .ADDR(IEPB_ADDR_LEVEL_EXT_B),
    .RST_VAL(IEPB_RST_LEVEL_EXT),
    .FIXED_MASK(8'h00),
    .FIXED_VAL(8'h00)
  ) u_level_ext_b (
    .clk(clk),
    .rst(rst),
    .wr_en(sfr_wr),
    .wr_addr(sfr_wr_addr),
    .wr_data(sfr_wr_data),
    .bit_wr_en(1'b0),
    .bit_addr(sfr_bit_addr),
    .bit_sel(sfr_bit_sel),
    .bit_val(sfr_bit_val),
    .value(level_ext_b)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Page select plays no part in the decode
  always_comb begin
    rd_hit_d = 1'b1;
    case (sfr_rd_addr)
      IEPB_ADDR_MASK_MAIN: rd_data_d = mask_main;
      IEPB_ADDR_LEVEL_MAIN: rd_data_d = level_main;
      IEPB_ADDR_MASK_EXT_A: rd_data_d = mask_ext_a;
      IEPB_ADDR_MASK_EXT_B: rd_data_d = mask_ext_b;
      IEPB_ADDR_LEVEL_EXT_A: rd_data_d = level_ext_a;
      IEPB_ADDR_LEVEL_EXT_B: rd_data_d = level_ext_b;
      default: begin
        rd_data_d = 8'h00;
        rd_hit_d = 1'b0;
      end
    endcase
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= 8'h00;
      rd_hit_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_hit_q <= rd_hit_d;
    end
  end

  assign sfr_rd_data = rd_data_q;
  assign sfr_rd_hit = rd_hit_q;
  assign global_irq_gate = mask_main[IEPB_BIT_GLOBAL_GATE];
  assign soft_scratch_flag = mask_main[IEPB_BIT_SCRATCH];

  // ----------------------------------------------------------------
  // Masking and level split
  // ----------------------------------------------------------------
  // Source vectors in vector order
  assign en_vec = {mask_ext_b, mask_ext_a, mask_main[IEPB_MAIN_SRC_BITS-1:0]};
  assign hi_vec = {level_ext_b, level_ext_a, level_main[IEPB_MAIN_SRC_BITS-1:0]};

  // Gate, per-source enable and level split
  always_comb begin
    live = mask_main[IEPB_BIT_GLOBAL_GATE] ? (pend_q & en_vec) : '0;
    live_hi = live & hi_vec;
    live_lo = live & ~hi_vec;
  end

  // High-level candidates
  iepb_arbiter #(
    .N(IEPB_NUM_SRC),
    .IW(IEPB_IDX_W)
  ) u_arb_hi (
    .req(live_hi),
    .any(any_hi),
    .idx(idx_hi)
  );

  // Low-level candidates
  iepb_arbiter #(
    .N(IEPB_NUM_SRC),
    .IW(IEPB_IDX_W)
  ) u_arb_lo (
    .req(live_lo),
    .any(any_lo),
    .idx(idx_lo)
  );

  // ----------------------------------------------------------------
  // Service tracking
  // ----------------------------------------------------------------
  // Levels in service; hold covers return plus one instruction
  always_comb begin
    svc_d = svc_q;
    hi_nest_d = hi_nest_q;
    hold_d = hold_q;
    if (isr_return) begin
      hold_d = 1'b1;
      case (svc_q)
        IEPB_SVC_HIGH: begin
          svc_d = hi_nest_q ? IEPB_SVC_LOW : IEPB_SVC_IDLE;
          hi_nest_d = 1'b0;
        end
        IEPB_SVC_LOW: svc_d = IEPB_SVC_IDLE;
        IEPB_SVC_IDLE: svc_d = IEPB_SVC_IDLE;
        default: svc_d = IEPB_SVC_IDLE;
      endcase
    end else if (insn_done) begin
      hold_d = 1'b0;
    end
    if (isr_enter && req_q) begin
      hold_d = 1'b0;
      if (lvl_q) begin
        hi_nest_d = (svc_q == IEPB_SVC_LOW);
        svc_d = IEPB_SVC_HIGH;
      end else begin
        svc_d = IEPB_SVC_LOW;
      end
    end
  end

  // Service state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      svc_q <= IEPB_SVC_IDLE;
      hi_nest_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      svc_q <= svc_d;
      hi_nest_q <= hi_nest_d;
      hold_q <= hold_d;
    end
  end

  // ----------------------------------------------------------------
  // Request decision
  // ----------------------------------------------------------------
  // High beats low; preemption only of a low routine
  always_comb begin
    req_d = 1'b0;
    idx_d = '0;
    lvl_d = 1'b0;
    // A return blocks at once; the hold flag only takes over next cycle
    if (!hold_q && !isr_enter && !isr_return) begin
      if (any_hi && svc_q != IEPB_SVC_HIGH) begin
        req_d = 1'b1;
        idx_d = idx_hi;
        lvl_d = 1'b1;
      end else if (any_lo && svc_q == IEPB_SVC_IDLE) begin
        req_d = 1'b1;
        idx_d = idx_lo;
      end
    end
  end

  // Pending sample and decision, every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= '0;
      req_q <= 1'b0;
      idx_q <= '0;
      lvl_q <= 1'b0;
    end else begin
      pend_q <= pend;
      req_q <= req_d;
      idx_q <= idx_d;
      lvl_q <= lvl_d;
    end
  end

  assign irq_req = req_q;
  assign irq_idx = idx_q;
  assign irq_hi = lvl_q;
endmodule

// file: sim/iepb_bank_asserts.sv
// Purpose: port-level checks of the interrupt bank
// Assumes: single clock, synchronous active-high reset
// Notes: service state rebuilt from the core handshake
`timescale 1ns/100ps
module iepb_bank_asserts
  import iepb_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic sfr_wr, // Byte write strobe
  input wire logic [7:0] sfr_wr_addr, // Byte write address
  input wire logic [7:0] sfr_wr_data, // Byte write data
  input wire logic [7:0] sfr_rd_addr, // Read address
  input wire logic [7:0] sfr_rd_data, // Read data
  input wire logic sfr_rd_hit, // Read hit
  input wire logic [iepb_pkg::IEPB_NUM_SRC-1:0] pend, // Pending flags
  input wire logic isr_enter, // Accept pulse
  input wire logic isr_return, // Return pulse
  input wire logic insn_done, // Instruction done
  input wire logic irq_req, // Request valid
  input wire logic [iepb_pkg::IEPB_IDX_W-1:0] irq_idx, // Winner index
  input wire logic irq_hi, // Winner level
  input wire logic global_irq_gate, // Gate bit
  input wire logic soft_scratch_flag // Scratch bit
);
  logic [IEPB_NUM_SRC-1:0] p1_q, p1_d, p2_q, p2_d;
  logic blk_q, blk_d, hi_q, hi_d, lo_q, lo_d, took;

  // --------------------------------------------------------------
  // Pend history and service levels
  // --------------------------------------------------------------
  always_comb begin
    took = isr_enter && irq_req;
    p1_d = pend;
    p2_d = p1_q;
    blk_d = isr_return || (blk_q && !insn_done);
    hi_d = hi_q ? !isr_return : (took && irq_hi);
    lo_d = lo_q ? !(isr_return && !hi_q) : (took && !irq_hi);
  end
  // History registers
  always_ff @(posedge clk) begin
    if (rst) begin
      {p1_q, p2_q, blk_q, hi_q, lo_q} <= '0;
    end else begin
      {p1_q, p2_q, blk_q, hi_q, lo_q} <= {p1_d, p2_d, blk_d, hi_d, lo_d};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_gate_off;
    !global_irq_gate [*2] |-> !irq_req;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("request with gate off");
  property p_req_src;
    irq_req |-> p2_q[irq_idx];
  endproperty
  a_req_src: assert property (p_req_src) else $error("winner not pending");
  property p_take_drop;
    isr_enter && irq_req |=> !irq_req;
  endproperty
  a_take_drop: assert property (p_take_drop) else $error("request kept after accept");
  property p_ret_block;
    isr_return || (blk_q && !insn_done) |=> !irq_req;
  endproperty
  a_ret_block: assert property (p_ret_block) else $error("request before return done");
  property p_hi_svc;
    hi_q |=> !irq_req;
  endproperty
  a_hi_svc: assert property (p_hi_svc) else $error("high routine preempted");
  property p_lo_svc;
    lo_q && !hi_q |=> !irq_req || irq_hi;
  endproperty
  a_lo_svc: assert property (p_lo_svc) else $error("low routine preempted by low");
  property p_lvl_rd;
    sfr_rd_addr == IEPB_ADDR_LEVEL_MAIN |=> sfr_rd_hit && sfr_rd_data[7:6] == 2'b11;
  endproperty
  a_lvl_rd: assert property (p_lvl_rd) else $error("main level top bits not set");
  property p_unmapped;
    !(sfr_rd_addr inside {8'hA8, 8'hB8, 8'hE6, 8'hE7, 8'hF6, 8'hF7})
      |=> sfr_rd_data == 8'h00 && !sfr_rd_hit;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_gate_wr;
    sfr_wr && sfr_wr_addr == IEPB_ADDR_MASK_MAIN
      |=> {global_irq_gate, soft_scratch_flag} == $past(sfr_wr_data[7:6]);
  endproperty
  a_gate_wr: assert property (p_gate_wr) else $error("gate or flag not written");
endmodule

bind iepb_bank iepb_bank_asserts iepb_bank_asserts_inst (
  .clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_wr_addr(sfr_wr_addr),
  .sfr_wr_data(sfr_wr_data), .sfr_rd_addr(sfr_rd_addr), .sfr_rd_data(sfr_rd_data),
  .sfr_rd_hit(sfr_rd_hit), .pend(pend), .isr_enter(isr_enter), .isr_return(isr_return),
  .insn_done(insn_done), .irq_req(irq_req), .irq_idx(irq_idx), .irq_hi(irq_hi),
  .global_irq_gate(global_irq_gate), .soft_scratch_flag(soft_scratch_flag)
);

// file: sim/iepb_core_model.sv
// Purpose: core stand-in that takes and ends service routines
// Assumes: bench allows each accept and asks for each return
// Notes: one instruction completes right after every return
`timescale 1ns/100ps
module iepb_core_model (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic take, // Accept allowed
  input wire logic ret_cmd, // Return wanted
  input wire logic irq_req, // Request from the bank
  output logic isr_enter, // Accept pulse
  output logic isr_return, // Return pulse
  output logic insn_done // Instruction done pulse
);
  logic enter_q, enter_d, ret_q, ret_d, done_q, done_d;
  // Next handshake pulses, accept only a live request
  always_comb begin
    enter_d = take && irq_req && !enter_q;
    ret_d = ret_cmd;
    done_d = ret_q;
  end
  // Pulse registers
  always_ff @(posedge clk) begin
    if (rst) begin
      {enter_q, ret_q, done_q} <= 3'h0;
    end else begin
      {enter_q, ret_q, done_q} <= {enter_d, ret_d, done_d};
    end
  end
  assign isr_enter = enter_q;
  assign isr_return = ret_q;
  assign insn_done = done_q;
endmodule

// file: sim/testbench.sv
// Purpose: self-checking bench for the interrupt bank
// Assumes: core model accepts under bench control
// Notes: reads and accepts are scored from queues
`timescale 1ns/100ps
module testbench;
  import iepb_pkg::*;
  logic clk, rst, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd_hit, take, ret_cmd, rd_go, rd_go_q;
  logic [7:0] sfr_wr_addr, sfr_wr_data, sfr_bit_addr, sfr_page, sfr_rd_addr, sfr_rd_data;
  logic [2:0] sfr_bit_sel;
  logic [IEPB_NUM_SRC-1:0] pend, lv22, pv;
  logic isr_enter, isr_return, insn_done, irq_req, irq_hi, global_irq_gate, soft_scratch_flag;
  logic [IEPB_IDX_W-1:0] irq_idx;
  logic [7:0] adr [6];
  logic [7:0] shd [6];
  logic [8:0] rdq [$];
  logic [8:0] irqq [$];
  int err_total, total_checks, n;

  iepb_bank iepb_bank_inst (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_wr_addr(sfr_wr_addr),
    .sfr_wr_data(sfr_wr_data), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_page(sfr_page),
    .sfr_rd_addr(sfr_rd_addr), .sfr_rd_data(sfr_rd_data), .sfr_rd_hit(sfr_rd_hit),
    .pend(pend), .isr_enter(isr_enter), .isr_return(isr_return), .insn_done(insn_done),
    .irq_req(irq_req), .irq_idx(irq_idx), .irq_hi(irq_hi),
    .global_irq_gate(global_irq_gate), .soft_scratch_flag(soft_scratch_flag));
  iepb_core_model iepb_core_model_inst (.clk(clk), .rst(rst), .take(take), .ret_cmd(ret_cmd),
    .irq_req(irq_req), .isr_enter(isr_enter), .isr_return(isr_return), .insn_done(insn_done));

  // Source view of the level shadows, for levels written well before use
  assign lv22 = {shd[5], shd[4], shd[1][5:0]};
  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Expected winner: high level first, then lowest index
  // Reads the shadows directly: a level written just before may not reach lv22 yet
  function automatic logic [8:0] pick(input logic [21:0] p);
    logic [21:0] m;
    logic [21:0] l;
    logic [8:0] r;
    m = p & {shd[3], shd[2], shd[0][5:0]} & {22{shd[0][7]}};
    l = {shd[5], shd[4], shd[1][5:0]};
    r = 9'h100;
    for (int k = 21; k >= 0; k--) if (m[k] && !l[k]) r = {4'h0, 5'(k)};
    for (int k = 21; k >= 0; k--) if (m[k] && l[k]) r = {4'h1, 5'(k)};
    return r;
  endfunction
  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    shd = '{8'h00, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    @(posedge clk);
    {sfr_wr, sfr_wr_addr, sfr_wr_data, sfr_page} <= {1'b1, adr[i], d, 8'($urandom)};
    @(posedge clk);
    sfr_wr <= 1'b0;
    shd[i] = (i == 1) ? (d | 8'hC0) : d;
  endtask
  task automatic bw(input int i, input logic [2:0] b, input logic v);
    @(posedge clk);
    {sfr_bit_wr, sfr_bit_addr, sfr_bit_sel, sfr_bit_val} <= {1'b1, adr[i], b, v};
    @(posedge clk);
    sfr_bit_wr <= 1'b0;
    if (i < 2 && !(i == 1 && b > 5)) shd[i][b] = v;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    @(posedge clk);
    {sfr_rd_addr, sfr_page, rd_go} <= {a, 8'($urandom), 1'b1};
    rdq.push_back(e);
    @(posedge clk);
    rd_go <= 1'b0;
  endtask
  task automatic rd_all;
    for (int i = 0; i < 6; i++) rd(adr[i], {1'b1, shd[i]});
    rd(8'h80, 9'h000);
  endtask
  // Let the core accept one request after a random delay
  task automatic take_it(input logic [8:0] e, input logic [21:0] np);
    irqq.push_back(e);
    repeat (2'($urandom)) @(posedge clk);
    @(posedge clk);
    take <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!isr_enter && n < 40);
    take <= 1'b0;
    pend <= np;
    if (n == 40) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic ret;
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic quiet(input int k);
    repeat (k) begin
      @(posedge clk);
      check({8'h00, irq_req}, 9'h000);
    end
  endtask

  // Score reads and accepted requests against the notes
  always @(posedge clk) begin
    rd_go_q <= rd_go;
    if (rd_go_q) check({sfr_rd_hit, sfr_rd_data}, rdq.pop_front());
    if (isr_enter && irq_req)
      check({3'h0, irq_hi, irq_idx}, irqq.size() ? irqq.pop_front() : 9'h100);
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {clk, sfr_wr, sfr_bit_wr, sfr_bit_val, take, ret_cmd, rd_go} = 7'h00;
    {sfr_wr_addr, sfr_wr_data, sfr_bit_addr, sfr_page, sfr_rd_addr, sfr_bit_sel} = '0;
    pend = '0;
    adr = '{8'hA8, 8'hB8, 8'hE6, 8'hE7, 8'hF6, 8'hF7};
    void'($urandom(76643));
    do_reset();
    rd_all();
    for (int i = 0; i < 6; i++) wr(i, 8'($urandom));
    rd_all();
    bw(0, 3'd6, ~shd[0][6]);
    bw(1, 3'd7, 1'b0);
    bw(1, 3'd1, ~shd[1][1]);
    bw(2, 3'd0, ~shd[2][0]);
    check({7'h00, global_irq_gate, soft_scratch_flag}, {7'h00, shd[0][7:6]});
    rd_all();
    // One source enabled at a time, others pending at random
    for (int i = 0; i < 22; i++) begin
      pv = 22'h1 << i;
      wr(0, {2'b10, pv[5:0]});
      wr(2, pv[13:6]);
      wr(3, pv[21:14]);
      pend <= 22'($urandom) | pv;
      take_it({3'h0, lv22[i], 5'(i)}, '0);
      ret();
    end
    wr(0, 8'h3F);
    wr(2, 8'hFF);
    wr(3, 8'hFF);
    pend <= '1;
    quiet(6);
    wr(2, 8'h00);
    wr(3, 8'h00);
    wr(0, 8'h80);
    quiet(6);
    pend <= '0;
    wr(0, 8'hBF);
    wr(2, 8'hFF);
    wr(3, 8'hFF);
    // Random levels and pending sets
    for (int t = 0; t < 16; t++) begin
      wr(1, 8'($urandom));
      wr(4, 8'($urandom));
      wr(5, 8'($urandom));
      pv = 22'($urandom) & 22'($urandom) & 22'($urandom);
      if (pv == '0) pv = 22'h1;
      pend <= pv;
      take_it(pick(pv), '0);
      ret();
    end
    // Nesting: low, then high preempts, then blocked
    wr(1, 8'h0C);
    wr(4, 8'h00);
    wr(5, 8'h00);
    pend <= 22'h3;
    take_it(9'h000, 22'h2);
    quiet(5);
    pend <= 22'hE;
    take_it(9'h022, 22'hA);
    quiet(5);
    ret();
    take_it(9'h023, 22'h2);
    ret();
    quiet(3);
    ret();
    take_it(9'h001, '0);
    ret();
    pend <= 22'h1;
    do_reset();
    rd_all();
    quiet(4);
    check(9'(rdq.size() + irqq.size()), 9'h000);
    give_verdict();
  end
endmodule
